// file: include/motor_config_defines.vh
// Register offsets, field positions, reset values and timing for motor config.
`ifndef MOTOR_CONFIG_DEFINES_VH
`define MOTOR_CONFIG_DEFINES_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ADDR_DRIVE_TACH_RES_CFG   8'h90
`define ADDR_BEMF_ADVANCE_CFG     8'h91
`define RESET_DRIVE_TACH_RES_CFG  16'h0000
`define RESET_BEMF_ADVANCE_CFG    16'h0000
`define BEMF_ADV_WRITE_MASK       16'h7FFF

// ----------------------------------------------------------------------
// Fields of the first configuration register
// ----------------------------------------------------------------------
`define SPREAD_MSB       15
`define SPREAD_LSB       14
`define TACH_OL_MSB      13
`define TACH_OL_LSB      12
`define POLE_DIV_MSB     11
`define POLE_DIV_LSB     8
`define CYCLE_ADJ_BIT    7
`define RES_SHIFT_MSB    6
`define RES_SHIFT_LSB    4
`define RES_MANT_MSB     3
`define RES_MANT_LSB     0

// ----------------------------------------------------------------------
// Fields of the second configuration register
// ----------------------------------------------------------------------
`define BEMF_RSVD_BIT    15
`define BEMF_SHIFT_MSB   14
`define BEMF_SHIFT_LSB   12
`define BEMF_MANT_MSB    11
`define BEMF_MANT_LSB    8
`define ADV_MODE_BIT     7
`define ADV_SHIFT_MSB    6
`define ADV_SHIFT_LSB    4
`define ADV_MANT_MSB     3
`define ADV_MANT_LSB     0

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define SPREAD_NONE      2'h0
`define SPREAD_5         2'h1
`define SPREAD_10        2'h2
`define SPREAD_15        2'h3
`define DITHER_PCT_0     5'h00
`define DITHER_PCT_5     5'h05
`define DITHER_PCT_10    5'h0A
`define DITHER_PCT_15    5'h0F
`define TACH_OL_BOTH     2'h0
`define TACH_OL_CLOSED   2'h1
`define TACH_OL_FIRST    2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SYS_CLK_KHZ      125000
`define TACH_DELAY_MS    280
`define TACH_DELAY_CYCLES (`TACH_DELAY_MS * `SYS_CLK_KHZ)

`endif

// file: verilog/shift_expand.v
// Mantissa shifted left by a shift count, giving the full-scale value.
`timescale 1ns/1ps

module shift_expand #(
    parameter MANT_W  = 4,
    parameter SHIFT_W = 3,
    parameter OUT_W   = 11
) (
    input  wire [MANT_W-1:0]  mantissa,
    input  wire [SHIFT_W-1:0] shift,
    output wire [OUT_W-1:0]   value
);

    // -----------------------------------------------------------------
    // Expansion
    // -----------------------------------------------------------------
    // The mantissa is widened first so no bits fall off the top.
    wire [OUT_W-1:0] mant_wide;

    assign mant_wide = {{(OUT_W-MANT_W){1'b0}}, mantissa};
    assign value     = mant_wide << shift;

endmodule // shift_expand

// file: verilog/motor_config_regs.v
// Configuration register pair of the motor driver and the logic they steer.
//
// Contract
// - Registers sit at 0x90 and 0x91 and reset to zero.
// - Bits 15:14 select no, 5, 10 or 15 percent frequency dither.
// - Bits 13:12 pick when tach output runs; 01 waits 280 ms closed loop.
// - Tach frequency is electrical speed divided by pole field plus one.
// - Bit 7 selects full-cycle (0) or half-cycle (1) adjustment.
// - Phase resistance is resistance mantissa shifted left by its shift.
// - BEMF constant is its mantissa shifted left by its shift.
// - Advance mode 1 with nonzero supply scales advance time by supply minus BEMF over supply.
// - Advance time is advance mantissa shifted left by its shift.
// - Shadow select runs from and reads back the shadow registers.
`timescale 1ns/1ps
`include "motor_config_defines.vh"

module motor_config_regs #(
    parameter V_W               = 8,
    parameter DLY_W             = 26,
    parameter TACH_DELAY_CYCLES = `TACH_DELAY_CYCLES
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire [7:0]       reg_addr,
    input  wire [15:0]      reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [15:0]      reg_rdata,
    output reg              reg_rack,
    input  wire             shadow_select,
    input  wire [15:0]      eeprom_cfg1,
    input  wire [15:0]      eeprom_cfg2,
    input  wire             loop_closed,
    input  wire             first_open_loop,
    input  wire             elec_edge,
    input  wire [V_W-1:0]   supply_volt,
    input  wire [V_W-1:0]   bemf_volt,
    output reg  [1:0]       spread_spectrum_sel,
    output reg  [4:0]       dither_pct,
    output reg              tach_output,
    output reg              cycle_adjust_granularity,
    output reg  [10:0]      phase_res_value,
    output reg  [10:0]      bemf_const_value,
    output reg              advance_mode,
    output reg  [10:0]      advance_time
);

    localparam NW = 11 + V_W;
    localparam [31:0] DLY_LAST = TACH_DELAY_CYCLES - 1;
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    localparam [31:0] DIV_LAST = NW - 1;

    // -----------------------------------------------------------------
    // Register storage
    // -----------------------------------------------------------------
    reg  [15:0]    cfg1_reg;
    reg  [15:0]    cfg2_reg;
    wire [15:0]    cfg1_eff;
    wire [15:0]    cfg2_eff;

    // Writes land in the shadow copy; bit 15 of the second is never kept.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg1_reg <= `RESET_DRIVE_TACH_RES_CFG;
            cfg2_reg <= `RESET_BEMF_ADVANCE_CFG;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_DRIVE_TACH_RES_CFG) begin
                cfg1_reg <= reg_wdata;
            end
            if (reg_addr == `ADDR_BEMF_ADVANCE_CFG) begin
                cfg2_reg <= reg_wdata & `BEMF_ADV_WRITE_MASK;
            end
        end
    end

    // Shadow copy or stored EEPROM image drives operation and readback.
    assign cfg1_eff = shadow_select ? cfg1_reg : eeprom_cfg1;
    assign cfg2_eff = (shadow_select ? cfg2_reg : eeprom_cfg2)
                      & `BEMF_ADV_WRITE_MASK;

    // -----------------------------------------------------------------
    // Read port
    // -----------------------------------------------------------------
    // Answer one cycle after the read strobe; unmapped offsets read zero.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_rack  <= 1'b0;
        end else begin
            reg_rack <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_DRIVE_TACH_RES_CFG: begin
                        reg_rdata <= cfg1_eff;
                    end
                    `ADDR_BEMF_ADVANCE_CFG: begin
                        reg_rdata <= cfg2_eff;
                    end
                    default: begin
                        reg_rdata <= 16'h0000;
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Shift and mantissa expansion
    // -----------------------------------------------------------------
    wire [10:0]    res_wide;
    wire [10:0]    bemf_wide;
    wire [10:0]    adv_wide;

    // Host side packs its value as top four bits plus a shift count.
    shift_expand #(.MANT_W(4), .SHIFT_W(3), .OUT_W(11)) u_res_expand (
        .mantissa (cfg1_eff[`RES_MANT_MSB:`RES_MANT_LSB]),
        .shift    (cfg1_eff[`RES_SHIFT_MSB:`RES_SHIFT_LSB]),
        .value    (res_wide)
    );

    shift_expand #(.MANT_W(4), .SHIFT_W(3), .OUT_W(11)) u_bemf_expand (
        .mantissa (cfg2_eff[`BEMF_MANT_MSB:`BEMF_MANT_LSB]),
        .shift    (cfg2_eff[`BEMF_SHIFT_MSB:`BEMF_SHIFT_LSB]),
        .value    (bemf_wide)
    );

    shift_expand #(.MANT_W(4), .SHIFT_W(3), .OUT_W(11)) u_adv_expand (
        .mantissa (cfg2_eff[`ADV_MANT_MSB:`ADV_MANT_LSB]),
        .shift    (cfg2_eff[`ADV_SHIFT_MSB:`ADV_SHIFT_LSB]),
        .value    (adv_wide)
    );

    // -----------------------------------------------------------------
    // Decoded configuration outputs
    // -----------------------------------------------------------------
    reg  [4:0]     dither_next;

    // Dither amount in percent from the spread-spectrum code.
    always @* begin
        case (cfg1_eff[`SPREAD_MSB:`SPREAD_LSB])
            `SPREAD_NONE: dither_next = `DITHER_PCT_0;
            `SPREAD_5:    dither_next = `DITHER_PCT_5;
            `SPREAD_10:   dither_next = `DITHER_PCT_10;
            default:      dither_next = `DITHER_PCT_15;
        endcase
    end

    // Field outputs other than advance_time and tach_output are registered copies of the effective setting.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            spread_spectrum_sel      <= 2'h0;
            dither_pct               <= 5'h00;
            cycle_adjust_granularity <= 1'b0;
            phase_res_value          <= 11'h000;
            bemf_const_value         <= 11'h000;
            advance_mode             <= 1'b0;
        end else begin
            spread_spectrum_sel      <= cfg1_eff[`SPREAD_MSB:`SPREAD_LSB];
            dither_pct               <= dither_next;
            cycle_adjust_granularity <= cfg1_eff[`CYCLE_ADJ_BIT];
            phase_res_value          <= res_wide;
            bemf_const_value         <= bemf_wide;
            advance_mode             <= cfg2_eff[`ADV_MODE_BIT];
        end
    end

    // -----------------------------------------------------------------
    // Tachometer gating and division
    // -----------------------------------------------------------------
    reg  [DLY_W-1:0] dly_cnt_reg;
    reg  [3:0]       pole_cnt_reg;
    reg              tach_en;
    wire             dly_done;
    wire [3:0]       pole_div;

    assign dly_done = (dly_cnt_reg == DLY_LAST[DLY_W-1:0]);
    assign pole_div = cfg1_eff[`POLE_DIV_MSB:`POLE_DIV_LSB];

    // Closed-loop time counter; it restarts whenever the loop opens.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_cnt_reg <= {DLY_W{1'b0}};
        end else if (!loop_closed) begin
            dly_cnt_reg <= {DLY_W{1'b0}};
        end else if (!dly_done) begin
            dly_cnt_reg <= dly_cnt_reg + 1'b1;
        end
    end

    // When the tach output is allowed to run; the reserved code keeps it off.
    always @* begin
        case (cfg1_eff[`TACH_OL_MSB:`TACH_OL_LSB])
            `TACH_OL_BOTH:   tach_en = 1'b1;
            `TACH_OL_CLOSED: tach_en = loop_closed & dly_done;
            `TACH_OL_FIRST:  tach_en = loop_closed | first_open_loop;
            default:         tach_en = 1'b0;
        endcase
    end

    // Toggle once every pole_div+1 half-cycle edges: a square wave at
    // electrical speed divided by pole_div+1.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pole_cnt_reg <= 4'h0;
            tach_output  <= 1'b0;
        end else if (!tach_en) begin
            pole_cnt_reg <= 4'h0;
            tach_output  <= 1'b0;
        end else if (elec_edge) begin
            if (pole_cnt_reg >= pole_div) begin
                pole_cnt_reg <= 4'h0;
                tach_output  <= ~tach_output;
            end else begin
                pole_cnt_reg <= pole_cnt_reg + 4'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Advance time scaling
    // -----------------------------------------------------------------
    reg              div_state_reg;
    reg  [NW-1:0]    div_num_reg;
    reg  [V_W:0]     div_rem_reg;
    reg  [V_W-1:0]   div_den_reg;
    reg  [4:0]       div_cnt_reg;
    reg  [10:0]      scaled_reg;
    wire [V_W-1:0]   headroom;
    wire [NW-1:0]    product;
    wire [V_W:0]     rem_shift;
    wire             rem_ge;

    // Supply below BEMF gives no headroom, so a nonzero supply shrinks the advance to zero.
    assign headroom  = (supply_volt > bemf_volt) ?
                       (supply_volt - bemf_volt) : {V_W{1'b0}};
    assign product   = adv_wide * headroom;
    assign rem_shift = {div_rem_reg[V_W-1:0], div_num_reg[NW-1]};
    assign rem_ge    = (rem_shift >= {1'b0, div_den_reg});

    // Serial restoring divider; a new quotient every NW+1 cycles.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_state_reg <= ST_IDLE;
            div_num_reg   <= {NW{1'b0}};
            div_rem_reg   <= {(V_W+1){1'b0}};
            div_den_reg   <= {V_W{1'b0}};
            div_cnt_reg   <= 5'h00;
            scaled_reg    <= 11'h000;
        end else begin
            case (div_state_reg)
                ST_IDLE: begin
                    if (supply_volt == {V_W{1'b0}}) begin
                        scaled_reg <= adv_wide;
                    end else begin
                        div_num_reg   <= product;
                        div_den_reg   <= supply_volt;
                        div_rem_reg   <= {(V_W+1){1'b0}};
                        div_cnt_reg   <= 5'h00;
                        div_state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    div_rem_reg <= rem_ge ?
                        (rem_shift - {1'b0, div_den_reg}) : rem_shift;
                    div_num_reg <= {div_num_reg[NW-2:0], rem_ge};
                    div_cnt_reg <= div_cnt_reg + 5'h01;
                    if (div_cnt_reg == DIV_LAST[4:0]) begin
                        scaled_reg    <= {div_num_reg[9:0], rem_ge};
                        div_state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    div_state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Fixed mode passes the setting; variable mode uses the scaled value.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            advance_time <= 11'h000;
        end else if (cfg2_eff[`ADV_MODE_BIT]) begin
            advance_time <= scaled_reg;
        end else begin
            advance_time <= adv_wide;
        end
    end

endmodule // motor_config_regs

// file: sim/motor_config_regs_properties.sv
// Concurrent checks on the ports of the motor configuration register block.
`timescale 1ns/1ps

module motor_config_regs_properties (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rack,
    input wire logic        shadow_select,
    input wire logic [15:0] eeprom_cfg1,
    input wire logic [15:0] eeprom_cfg2,
    input wire logic        elec_edge,
    input wire logic [1:0]  spread_spectrum_sel,
    input wire logic [4:0]  dither_pct,
    input wire logic        tach_output,
    input wire logic [10:0] phase_res_value,
    input wire logic [10:0] bemf_const_value,
    input wire logic        advance_mode,
    input wire logic [10:0] advance_time
);
    // All checks share the system clock and its reset.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // One cycle in which the stored image drives operation unchanged.
    sequence image_steady;
        !shadow_select && $stable(eeprom_cfg1) && $stable(eeprom_cfg2);
    endsequence

    a_rack_echo: assert property (reg_rd |=> reg_rack)
        else $error("read strobe not acknowledged");
    a_rack_pulse: assert property (!reg_rd |=> !reg_rack)
        else $error("acknowledge without read strobe");
    a_dither_code: assert property (
        dither_pct == {3'h0, spread_spectrum_sel} * 5'h05)
        else $error("dither percent does not match code");
    a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h90
        && reg_addr != 8'h91 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (
        reg_rd && reg_addr == 8'h91 |=> !reg_rdata[15])
        else $error("reserved bit reads one");
    a_image_read: assert property (reg_rd && !shadow_select
        && reg_addr == 8'h90 |=> reg_rdata == $past(eeprom_cfg1))
        else $error("readback not from stored image");
    a_tach_off: assert property (
        image_steady [*4] ##0 eeprom_cfg1[13:12] == 2'h3 |-> !tach_output)
        else $error("tach output active in reserved mode");
    a_tach_cause: assert property (
        $rose(tach_output) |-> $past(elec_edge))
        else $error("tach output rose without edge");
    a_image_decode: assert property (image_steady [*4] |->
        phase_res_value == ({7'h00, eeprom_cfg1[3:0]} << eeprom_cfg1[6:4])
        && bemf_const_value ==
        ({7'h00, eeprom_cfg2[11:8]} << eeprom_cfg2[14:12]))
        else $error("shifted values wrong");
    a_fixed_advance: assert property (
        image_steady [*4] ##0 !eeprom_cfg2[7] |-> !advance_mode &&
        advance_time == ({7'h00, eeprom_cfg2[3:0]} << eeprom_cfg2[6:4]))
        else $error("fixed advance time wrong");
endmodule // motor_config_regs_properties

// file: sim/cfg_host_model.sv
// Host model that drives the register strobe port.
`timescale 1ns/1ps

module cfg_host_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rack,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    // Idle port: strobes low before reset is released.
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One write strobe; released lines are parked on inverted values.
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
        repeat (2) @(negedge sys_clk);
    endtask

    // One read strobe, then a bounded wait for the acknowledge.
    task automatic read_reg(input logic [7:0] a, output logic [15:0] q,
                            output logic ok);
        int n;
        ok = 1'b0;
        q  = 16'h0000;
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        for (n = 0; n < 4 && !ok; n++) begin
            if (reg_rack === 1'b1) begin
                q  = reg_rdata;
                ok = 1'b1;
            end else begin
                @(negedge sys_clk);
            end
        end
    endtask

    // Splits a raw resistance count into top four bits and a count of dropped bits.
    function automatic logic [6:0] encode_res(input logic [10:0] raw);
        logic [2:0] s;
        s = 3'h0;
        while ((raw >> s) > 11'h00F) s++;
        return {s, 4'(raw >> s)};
    endfunction
endmodule // cfg_host_model

// file: sim/motor_config_regs_tb_top.sv
// Self-checking testbench for the motor configuration register block.
`timescale 1ns/1ps

module motor_config_regs_tb_top;
    logic        sys_clk, rst_n, reg_wr, reg_rd, reg_rack;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, eeprom_cfg1, eeprom_cfg2, d;
    logic        shadow_select, loop_closed, first_open_loop, elec_edge;
    logic [7:0]  supply_volt, bemf_volt;
    logic [1:0]  spread_spectrum_sel;
    logic [4:0]  dither_pct;
    logic        tach_output, cycle_adjust_granularity, advance_mode;
    logic [10:0] phase_res_value, bemf_const_value, advance_time;
    int          bad_count, samples_checked, i;

    motor_config_regs #(.TACH_DELAY_CYCLES(20)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rack(reg_rack),
        .shadow_select(shadow_select), .eeprom_cfg1(eeprom_cfg1),
        .eeprom_cfg2(eeprom_cfg2), .loop_closed(loop_closed),
        .first_open_loop(first_open_loop), .elec_edge(elec_edge),
        .supply_volt(supply_volt), .bemf_volt(bemf_volt),
        .spread_spectrum_sel(spread_spectrum_sel), .dither_pct(dither_pct),
        .tach_output(tach_output),
        .cycle_adjust_granularity(cycle_adjust_granularity),
        .phase_res_value(phase_res_value),
        .bemf_const_value(bemf_const_value),
        .advance_mode(advance_mode), .advance_time(advance_time));

    cfg_host_model host (
        .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rack(reg_rack),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd));

    // Clock of 8 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Prints the verdict and ends the run.
    task automatic results;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Compares a decoded output, zero-extended to 16 bits.
    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: output 0x%h expected 0x%h",
                     $time, got, exp);
        end
    endtask

    // Reads a register and compares the returned word.
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] q;
        logic        ok;
        host.read_reg(a, q, ok);
        samples_checked++;
        if (!ok) begin
            bad_count++;
            $display("Error at %0t: no read acknowledge", $time);
            results();
        end else if (q !== exp) begin
            bad_count++;
            $display("Error at %0t: read 0x%h expected 0x%h", $time, q, exp);
        end
    endtask

    // Pulses the electrical edge n times and checks the tach level.
    task automatic edge_chk(input int n, input logic exp);
        repeat (n) begin
            @(negedge sys_clk);
            elec_edge = 1'b1;
            @(negedge sys_clk);
            elec_edge = 1'b0;
        end
        @(negedge sys_clk);
        chk_out({15'h0000, tach_output}, {15'h0000, exp});
    endtask

    // Cuts a hung run short.
    initial begin
        #400000;
        bad_count++;
        $display("Error at %0t: run did not finish", $time);
        results();
    end

    // Main sequence of register accesses and expected values.
    initial begin
        bad_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        shadow_select = 1'b1;
        eeprom_cfg1 = 16'h0000;
        eeprom_cfg2 = 16'h0000;
        loop_closed = 1'b0;
        first_open_loop = 1'b0;
        elec_edge = 1'b0;
        supply_volt = 8'h64;
        bemf_volt = 8'h32;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        rd_chk(8'h90, 16'h0000);
        rd_chk(8'h91, 16'h0000);
        rd_chk(8'h92, 16'h0000);
        rd_chk(8'h8F, 16'h0000);
        for (i = 0; i < 4; i++) begin
            d = {i[1:0], 6'h00, i[0], 3'(2 * i + 1), 4'h9};
            host.write_reg(8'h90, d);
            rd_chk(8'h90, d);
            chk_out({14'h0, spread_spectrum_sel}, {14'h0, i[1:0]});
            chk_out({11'h0, dither_pct}, 16'(i * 5));
            chk_out({15'h0, cycle_adjust_granularity}, {15'h0, i[0]});
            chk_out({5'h0, phase_res_value}, 16'(11'h9 << (2 * i + 1)));
        end
        host.write_reg(8'h90, {9'h000, host.encode_res(11'h0B7)});
        chk_out({5'h0, phase_res_value}, 16'h00B0);
        host.write_reg(8'h91, 16'hFFFF);
        rd_chk(8'h91, 16'h7FFF);
        chk_out({5'h0, bemf_const_value}, 16'h0780);
        host.write_reg(8'h91, 16'h3123);
        chk_out({5'h0, bemf_const_value}, 16'h0008);
        chk_out({5'h0, advance_time}, 16'h000C);
        chk_out({15'h0, advance_mode}, 16'h0000);
        host.write_reg(8'h91, 16'h00A3);
        chk_out({15'h0, advance_mode}, 16'h0001);
        repeat (45) @(negedge sys_clk);
        chk_out({5'h0, advance_time}, 16'h0006);
        bemf_volt = 8'h70;
        repeat (45) @(negedge sys_clk);
        chk_out({5'h0, advance_time}, 16'h0000);
        supply_volt = 8'h00;
        repeat (45) @(negedge sys_clk);
        chk_out({5'h0, advance_time}, 16'h000C);
        host.write_reg(8'h90, 16'h3000);
        edge_chk(1, 1'b0);
        first_open_loop = 1'b1;
        host.write_reg(8'h90, 16'h2000);
        edge_chk(1, 1'b1);
        host.write_reg(8'h90, 16'h3000);
        first_open_loop = 1'b0;
        loop_closed = 1'b1;
        host.write_reg(8'h90, 16'h1000);
        edge_chk(1, 1'b0);
        repeat (25) @(negedge sys_clk);
        edge_chk(1, 1'b1);
        host.write_reg(8'h90, 16'h3000);
        loop_closed = 1'b0;
        host.write_reg(8'h90, 16'h0200);
        edge_chk(2, 1'b0);
        edge_chk(1, 1'b1);
        eeprom_cfg1 = 16'h7025;
        eeprom_cfg2 = 16'hC215;
        shadow_select = 1'b0;
        repeat (6) @(negedge sys_clk);
        rd_chk(8'h90, 16'h7025);
        rd_chk(8'h91, 16'h4215);
        chk_out({11'h0, dither_pct}, 16'h0005);
        chk_out({5'h0, phase_res_value}, 16'h0014);
        chk_out({5'h0, bemf_const_value}, 16'h0020);
        chk_out({5'h0, advance_time}, 16'h000A);
        chk_out({15'h0, tach_output}, 16'h0000);
        shadow_select = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk_out({11'h0, dither_pct}, 16'h0000);
        results();
    end
endmodule // motor_config_regs_tb_top

bind motor_config_regs motor_config_regs_properties chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rack(reg_rack),
    .shadow_select(shadow_select), .eeprom_cfg1(eeprom_cfg1),
    .eeprom_cfg2(eeprom_cfg2), .elec_edge(elec_edge),
    .spread_spectrum_sel(spread_spectrum_sel), .dither_pct(dither_pct),
    .tach_output(tach_output), .phase_res_value(phase_res_value),
    .bemf_const_value(bemf_const_value), .advance_mode(advance_mode),
    .advance_time(advance_time));
